// ---- src/pbmp_top.sv ----
// Peripheral register bus, cycle stretching and paged memory interface
`timescale 1ns/1ps
module pbmp_top #(
  parameter pbmp_pkg::pbmp_variant_t VARIANT = pbmp_pkg::VAR_MAC
) (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Peripheral bus from the core
  input  wire pbmp_pkg::pbmp_pb_req_t        pb_req,
  output logic                               pb_wait,
  output logic      [pbmp_pkg::DW-1:0]       pb_rdata,
  output pbmp_pkg::pbmp_push_t               pb_push,
  // Timer slots
  input  wire logic [pbmp_pkg::DW-1:0]       timer1_count,
  input  wire logic [pbmp_pkg::DW-1:0]       timer2_count,
  output logic      [pbmp_pkg::DW-1:0]       timer1_preload,
  output logic      [pbmp_pkg::DW-1:0]       timer2_preload,
  output logic                               timer1_load,
  output logic                               timer2_load,
  // Multiplier and scratch support
  input  wire logic [pbmp_pkg::PROD_W-1:0]   product,
  input  wire logic                          mac_load,
  input  wire logic [pbmp_pkg::DW-1:0]       mac_low,
  input  wire logic [pbmp_pkg::DW-1:0]       mac_mid,
  input  wire logic                          scratch_inc,
  input  wire logic                          scratch_dec,
  // Memory access from the core
  input  wire pbmp_pkg::pbmp_mem_req_t       mem_req,
  input  wire logic                          fetch_done,
  input  wire logic [pbmp_pkg::DW-1:0]       stack_top,
  input  wire logic [pbmp_pkg::DW-1:0]       stack_next,
  output logic                               mem_wait,
  output logic      [pbmp_pkg::DW-1:0]       mem_load_data,
  output logic                               mem_load_pop,
  output logic                               irq_holdoff,
  output logic                               data_page_select,
  // Memory pins
  output logic      [pbmp_pkg::MA_W-1:1]     memory_address_pins,
  output logic      [pbmp_pkg::DW-1:0]       memory_data_pins_o,
  output logic                               memory_data_pins_oe,
  input  wire logic [pbmp_pkg::DW-1:0]       memory_data_pins_i,
  // Off-chip peripheral pins
  output logic      [pbmp_pkg::EXT_AW-1:0]   peripheral_address_pins,
  output logic      [pbmp_pkg::DW-1:0]       peripheral_data_pins_o,
  output logic                               peripheral_data_pins_oe,
  input  wire logic [pbmp_pkg::DW-1:0]       peripheral_data_pins_i,
  output logic                               peripheral_rd,
  output logic                               peripheral_wr
);
  import pbmp_pkg::*;

  generate
    if (!(VARIANT inside {VAR_MULT, VAR_SCRATCH, VAR_MAC})) begin : g_bad_variant
      $error("pbmp_top: unsupported VARIANT");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } pbmp_state_t;

  localparam logic IS_MAC = (VARIANT == VAR_MAC);

  // Configuration bits
  logic user_cycle_stretch_reg, user_cycle_stretch_next;
  logic peripheral_read_stretch_reg, peripheral_read_stretch_next;
  logic round_reg, round_next;
  logic data_page_select_reg, data_page_select_next;

  // Timer preloads
  logic [DW-1:0] t1_pre_reg, t1_pre_next, t2_pre_reg, t2_pre_next;
  logic          t1_load_reg, t1_load_next, t2_load_reg, t2_load_next;

  // Read answer
  logic [DW-1:0] rdata_reg, rdata_next;
  pbmp_push_t    push_reg, push_next;

  // Memory read answer
  logic [DW-1:0] mload_reg, mload_next;
  logic          mpop_reg, mpop_next;

  // Stretch machine
  pbmp_state_t state_reg, state_next;
  logic        need_stretch;
  logic        stall;

  // Decode
  logic          pb_any, pb_go, pb_ext, pb_rd_go, pb_wr_go;
  logic          mem_any, mem_go;
  logic          wr_lo, wr_hi, wr_dpr, wr_cpr;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] lo_q, hi_q;
  logic [PAGE_W-1:0] cpr_q, dpr_q;
  logic [MA_W-1:0]   mem_addr;
  logic [DW-1:0]     ibc_view, cr_view;

  assign pb_any  = pb_req.rd | pb_req.wr;
  assign pb_ext  = (pb_req.addr >= PB_EXT_BASE);
  assign mem_any = mem_req.rd | mem_req.wr;

  // Which requests get one extra clock
  always_comb begin
    need_stretch = 1'b0;
    if (mem_any && mem_req.user && user_cycle_stretch_reg) begin
      need_stretch = 1'b1;
    end
    if (!IS_MAC && mem_req.interrupt_ack_cycle && user_cycle_stretch_reg) begin
      need_stretch = 1'b1;
    end
    if (IS_MAC && pb_req.rd && pb_ext && peripheral_read_stretch_reg) begin
      need_stretch = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    stall      = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (need_stretch) begin
          stall      = 1'b1;
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign pb_wait  = stall & pb_any;
  assign mem_wait = stall & (mem_any | mem_req.interrupt_ack_cycle);
  // Each peripheral access completes in its own cycle unless stretched
  assign pb_go    = pb_any & ~stall;
  assign mem_go   = mem_any & ~stall;
  assign pb_rd_go = pb_go & pb_req.rd;
  assign pb_wr_go = pb_go & pb_req.wr;

  assign wr_lo  = pb_wr_go && (pb_req.addr == PB_PROD_LO) && (VARIANT != VAR_MULT);
  assign wr_hi  = pb_wr_go && (pb_req.addr == PB_PROD_HI) && (VARIANT != VAR_MULT);
  assign wr_dpr = pb_wr_go && (pb_req.addr == PB_DPR);
  assign wr_cpr = pb_wr_go && (pb_req.addr == PB_CPR);

  assign ibc_view = (DW'(user_cycle_stretch_reg) << IBC_STRETCH_BIT)
                  | (DW'(round_reg) << IBC_ROUND_BIT)
                  | (DW'(data_page_select_reg) << IBC_DPSEL_BIT);
  assign cr_view  = DW'(peripheral_read_stretch_reg) << CR_RDSTR_BIT;

  // Read data selection
  always_comb begin
    rd_val = REG_RESET;
    if (pb_ext) begin
      rd_val = peripheral_data_pins_i;
    end else begin
      unique case (pb_req.addr)
        PB_TIMER1:  rd_val = timer1_count;
        PB_TIMER2:  rd_val = timer2_count;
        PB_PROD_LO: rd_val = lo_q;
        PB_PROD_HI: rd_val = hi_q;
        PB_DPR:     rd_val = DW'(dpr_q);
        PB_CPR:     rd_val = DW'(cpr_q);
        PB_IBC:     rd_val = ibc_view;
        PB_CR:      rd_val = cr_view;
        default:    rd_val = REG_RESET;
      endcase
    end
  end

  // Peripheral answer and push kind
  always_comb begin
    rdata_next = rdata_reg;
    push_next  = PUSH_NONE;
    if (pb_rd_go) begin
      rdata_next = rd_val;
      push_next  = PUSH_FULL;
      if ((VARIANT == VAR_MULT)
          && (pb_req.addr == PB_PROD_LO || pb_req.addr == PB_PROD_HI)) begin
        push_next = PUSH_SHIFT;
      end
    end
  end

  // Timer preload slots
  always_comb begin
    t1_pre_next  = t1_pre_reg;
    t2_pre_next  = t2_pre_reg;
    t1_load_next = 1'b0;
    t2_load_next = 1'b0;
    if (pb_wr_go && pb_req.addr == PB_TIMER1) begin
      t1_pre_next  = pb_req.wdata;
      t1_load_next = 1'b1;
    end
    if (pb_wr_go && pb_req.addr == PB_TIMER2) begin
      t2_pre_next  = pb_req.wdata;
      t2_load_next = 1'b1;
    end
  end

  // Configuration writes
  always_comb begin
    user_cycle_stretch_next      = user_cycle_stretch_reg;
    round_next                   = round_reg;
    data_page_select_next        = data_page_select_reg;
    peripheral_read_stretch_next = peripheral_read_stretch_reg;
    if (pb_wr_go && pb_req.addr == PB_IBC) begin
      user_cycle_stretch_next = pb_req.wdata[IBC_STRETCH_BIT];
      round_next              = pb_req.wdata[IBC_ROUND_BIT];
      data_page_select_next   = pb_req.wdata[IBC_DPSEL_BIT];
    end
    if (IS_MAC && pb_wr_go && pb_req.addr == PB_CR) begin
      peripheral_read_stretch_next = pb_req.wdata[CR_RDSTR_BIT];
    end
  end

  // Memory read: word lands in the second register on the same clock that the stack pops
  always_comb begin
    mload_next = mload_reg;
    mpop_next  = 1'b0;
    if (mem_go && mem_req.rd && !mem_req.fetch) begin
      mload_next = memory_data_pins_i;
      mpop_next  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg                   <= ST_IDLE;
      user_cycle_stretch_reg      <= 1'b0;
      peripheral_read_stretch_reg <= 1'b0;
      round_reg                   <= 1'b0;
      data_page_select_reg        <= 1'b0;
      t1_pre_reg                  <= REG_RESET;
      t2_pre_reg                  <= REG_RESET;
      t1_load_reg                 <= 1'b0;
      t2_load_reg                 <= 1'b0;
      rdata_reg                   <= REG_RESET;
      push_reg                    <= PUSH_NONE;
      mload_reg                   <= REG_RESET;
      mpop_reg                    <= 1'b0;
    end else begin
      state_reg                   <= state_next;
      user_cycle_stretch_reg      <= user_cycle_stretch_next;
      peripheral_read_stretch_reg <= peripheral_read_stretch_next;
      round_reg                   <= round_next;
      data_page_select_reg        <= data_page_select_next;
      t1_pre_reg                  <= t1_pre_next;
      t2_pre_reg                  <= t2_pre_next;
      t1_load_reg                 <= t1_load_next;
      t2_load_reg                 <= t2_load_next;
      rdata_reg                   <= rdata_next;
      push_reg                    <= push_next;
      mload_reg                   <= mload_next;
      mpop_reg                    <= mpop_next;
    end
  end

  pbmp_prod_regs #(
    .VARIANT (VARIANT)
  ) u_prod (
    .clock    (clock),
    .rstn     (rstn),
    .wr_lo    (wr_lo),
    .wr_hi    (wr_hi),
    .wdata    (pb_req.wdata),
    .inc      (scratch_inc),
    .dec      (scratch_dec),
    .round_en (round_reg),
    .product  (product),
    .mac_load (mac_load),
    .mac_low  (mac_low),
    .mac_mid  (mac_mid),
    .lo_q     (lo_q),
    .hi_q     (hi_q)
  );

  pbmp_pager u_pager (
    .clock       (clock),
    .rstn        (rstn),
    .wr_dpr      (wr_dpr),
    .wr_cpr      (wr_cpr),
    .wpage       (pb_req.wdata[PAGE_W-1:0]),
    .fetch_done  (fetch_done),
    .data_sel    (data_page_select_reg),
    .fetch       (mem_req.fetch),
    .top         (stack_top),
    .addr        (mem_addr),
    .cpr_q       (cpr_q),
    .dpr_q       (dpr_q),
    .irq_holdoff (irq_holdoff)
  );

  // Word address pins; byte bit 0 stays inside
  assign memory_address_pins = mem_addr[MA_W-1:1];
  assign memory_data_pins_o  = stack_next;
  assign memory_data_pins_oe = mem_req.wr;

  // External peripheral strobes only for the top eight locations; address and data out follow every access
  assign peripheral_address_pins = pb_req.addr[EXT_AW-1:0];
  assign peripheral_rd           = pb_req.rd & pb_ext;
  assign peripheral_wr           = pb_wr_go & pb_ext;
  assign peripheral_data_pins_o  = pb_req.wdata;
  assign peripheral_data_pins_oe = pb_wr_go & pb_ext;

  assign pb_rdata         = rdata_reg;
  assign pb_push          = push_reg;
  assign mem_load_data    = mload_reg;
  assign mem_load_pop     = mpop_reg;
  assign timer1_preload   = t1_pre_reg;
  assign timer2_preload   = t2_pre_reg;
  assign timer1_load      = t1_load_reg;
  assign timer2_load      = t2_load_reg;
  assign data_page_select = data_page_select_reg;

endmodule

// ---- src/pbmp_pkg.sv ----
// Shared constants and types for the peripheral bus and memory paging block
package pbmp_pkg;

  localparam int DW      = 16;
  localparam int AW      = 5;
  localparam int PAGE_W  = 4;
  localparam int MA_W    = 20;
  localparam int PROD_W  = 32;
  localparam int EXT_AW  = 3;

  // Peripheral bus locations
  localparam logic [AW-1:0] PB_CR       = 5'h00;
  localparam logic [AW-1:0] PB_DPR      = 5'h0D;
  localparam logic [AW-1:0] PB_CPR      = 5'h0F;
  localparam logic [AW-1:0] PB_IBC      = 5'h10;
  localparam logic [AW-1:0] PB_TIMER1   = 5'h14;
  localparam logic [AW-1:0] PB_TIMER2   = 5'h15;
  localparam logic [AW-1:0] PB_PROD_LO  = 5'h16;
  localparam logic [AW-1:0] PB_PROD_HI  = 5'h17;
  localparam logic [AW-1:0] PB_EXT_BASE = 5'h18;

  // Field positions
  localparam int IBC_STRETCH_BIT = 7;
  localparam int IBC_ROUND_BIT   = 6;
  localparam int IBC_DPSEL_BIT   = 5;
  localparam int CR_RDSTR_BIT    = 13;

  // Reset values
  localparam logic [DW-1:0]     REG_RESET  = 16'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;

  typedef enum logic [1:0] {
    VAR_MULT    = 2'h0,
    VAR_SCRATCH = 2'h1,
    VAR_MAC     = 2'h2
  } pbmp_variant_t;

  typedef enum logic [2:0] {
    PUSH_NONE  = 3'b001,
    PUSH_FULL  = 3'b010,
    PUSH_SHIFT = 3'b100
  } pbmp_push_t;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pbmp_pb_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic fetch;
    logic user;
    logic interrupt_ack_cycle;
  } pbmp_mem_req_t;

endpackage

// ---- src/pbmp_prod_regs.sv ----
// Variant dependent registers at product low and product high locations
`timescale 1ns/1ps
module pbmp_prod_regs #(
  parameter pbmp_pkg::pbmp_variant_t VARIANT = pbmp_pkg::VAR_MAC
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        wr_lo,
  input  wire logic                        wr_hi,
  input  wire logic [pbmp_pkg::DW-1:0]     wdata,
  input  wire logic                        inc,
  input  wire logic                        dec,
  input  wire logic                        round_en,
  input  wire logic [pbmp_pkg::PROD_W-1:0] product,
  input  wire logic                        mac_load,
  input  wire logic [pbmp_pkg::DW-1:0]     mac_low,
  input  wire logic [pbmp_pkg::DW-1:0]     mac_mid,
  output logic      [pbmp_pkg::DW-1:0]     lo_q,
  output logic      [pbmp_pkg::DW-1:0]     hi_q
);
  import pbmp_pkg::*;

  logic [DW-1:0] lo_reg, lo_next, hi_reg, hi_next;
  logic [DW-1:0] prod_hi_rnd, mac_mid_rnd;

  // Rounding folds the top bit of the low half into the high half
  assign prod_hi_rnd = product[PROD_W-1:DW] + DW'(round_en & product[DW-1]);
  assign mac_mid_rnd = mac_mid + DW'(round_en & mac_low[DW-1]);

  always_comb begin
    lo_next = lo_reg;
    hi_next = hi_reg;
    unique case (VARIANT)
      VAR_MULT: begin
        lo_next = product[DW-1:0];
        hi_next = prod_hi_rnd;
      end
      VAR_SCRATCH: begin
        if (wr_lo) begin
          lo_next = wdata;
        end else if (inc) begin
          lo_next = lo_reg + DW'(1);
        end else if (dec) begin
          lo_next = lo_reg - DW'(1);
        end
        if (wr_hi) begin
          hi_next = wdata;
        end
      end
      VAR_MAC: begin
        if (wr_lo) begin
          lo_next = wdata;
        end else if (mac_load) begin
          lo_next = mac_low;
        end
        if (wr_hi) begin
          hi_next = wdata;
        end else if (mac_load) begin
          hi_next = mac_mid_rnd;
        end
      end
      default: begin
        lo_next = lo_reg;
        hi_next = hi_reg;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lo_reg <= REG_RESET;
      hi_reg <= REG_RESET;
    end else begin
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end

  assign lo_q = lo_reg;
  assign hi_q = hi_reg;

endmodule

// ---- src/pbmp_pager.sv ----
// Code and data page registers with the delayed code page switch
`timescale 1ns/1ps
module pbmp_pager (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        wr_dpr,
  input  wire logic                        wr_cpr,
  input  wire logic [pbmp_pkg::PAGE_W-1:0] wpage,
  input  wire logic                        fetch_done,
  input  wire logic                        data_sel,
  input  wire logic                        fetch,
  input  wire logic [pbmp_pkg::DW-1:0]     top,
  output logic      [pbmp_pkg::MA_W-1:0]   addr,
  output logic      [pbmp_pkg::PAGE_W-1:0] cpr_q,
  output logic      [pbmp_pkg::PAGE_W-1:0] dpr_q,
  output logic                             irq_holdoff
);
  import pbmp_pkg::*;

  logic [PAGE_W-1:0] cpr_reg, cpr_next, dpr_reg, dpr_next;
  logic [PAGE_W-1:0] pend_reg, pend_next;
  logic              pend_valid_reg, pend_valid_next;
  logic              hold_reg, hold_next;
  logic [PAGE_W-1:0] page;

  always_comb begin
    dpr_next        = wr_dpr ? wpage : dpr_reg;
    cpr_next        = cpr_reg;
    pend_next       = pend_reg;
    pend_valid_next = pend_valid_reg;
    hold_next       = wr_cpr;
    if (wr_cpr) begin
      pend_next       = wpage;
      pend_valid_next = 1'b1;
    end
    // Commit only after one more fetch from the old page
    if (fetch_done && (pend_valid_reg || wr_cpr)) begin
      cpr_next        = wr_cpr ? wpage : pend_reg;
      pend_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpr_reg        <= PAGE_RESET;
      dpr_reg        <= PAGE_RESET;
      pend_reg       <= PAGE_RESET;
      pend_valid_reg <= 1'b0;
      hold_reg       <= 1'b0;
    end else begin
      cpr_reg        <= cpr_next;
      dpr_reg        <= dpr_next;
      pend_reg       <= pend_next;
      pend_valid_reg <= pend_valid_next;
      hold_reg       <= hold_next;
    end
  end

  assign page        = (!fetch && data_sel) ? dpr_reg : cpr_reg;
  assign addr        = {page, top};
  assign cpr_q       = cpr_reg;
  assign dpr_q       = dpr_reg;
  assign irq_holdoff = hold_reg;

endmodule

// ---- sim/pbmp_top_chk.sv ----
// Port-level assertions for the paged bus block
`timescale 1ns/1ps
module pbmp_top_chk (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire pbmp_pkg::pbmp_pb_req_t  pb_req,
  input wire logic                    pb_wait,
  input wire logic [15:0]             pb_rdata,
  input wire pbmp_pkg::pbmp_push_t    pb_push,
  input wire logic [15:0]             timer1_count,
  input wire logic [15:0]             timer1_preload,
  input wire logic                    timer1_load,
  input wire pbmp_pkg::pbmp_mem_req_t mem_req,
  input wire logic                    mem_wait,
  input wire logic [15:0]             stack_next,
  input wire logic [15:0]             mem_load_data,
  input wire logic                    mem_load_pop,
  input wire logic [15:0]             memory_data_pins_o,
  input wire logic                    memory_data_pins_oe,
  input wire logic [15:0]             memory_data_pins_i,
  input wire logic [2:0]              peripheral_address_pins,
  input wire logic [15:0]             peripheral_data_pins_i,
  input wire logic                    peripheral_rd,
  input wire logic                    peripheral_wr
);
  import pbmp_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_ext_rd_held;
    pb_req.rd && pb_req.addr >= PB_EXT_BASE && pb_wait && peripheral_rd;
  endsequence
  sequence s_ext_rd_done;
    peripheral_rd && !pb_wait ##1 pb_rdata == $past(peripheral_data_pins_i);
  endsequence
  chk_timer_read: assert property (pb_req.rd && pb_req.addr == PB_TIMER1 && !pb_wait
    |=> pb_rdata == $past(timer1_count) && pb_push == PUSH_FULL) else $error("timer read");
  chk_preload_write: assert property (pb_req.wr && pb_req.addr == PB_TIMER1
    |=> timer1_load && timer1_preload == $past(pb_req.wdata)) else $error("preload write");
  chk_ext_addr: assert property ((pb_req.rd || pb_req.wr)
    |-> peripheral_address_pins == pb_req.addr[2:0]) else $error("ext address");
  chk_int_quiet: assert property ((pb_req.rd || pb_req.wr) && pb_req.addr < PB_EXT_BASE
    |-> !peripheral_rd && !peripheral_wr) else $error("internal access on pins");
  chk_ext_word: assert property (pb_req.rd && pb_req.addr >= PB_EXT_BASE && !pb_wait
    |=> pb_rdata == $past(peripheral_data_pins_i)) else $error("ext read word");
  chk_rd_stretch: assert property (s_ext_rd_held |=> s_ext_rd_done)
    else $error("stretched ext read");
  chk_mem_wdata: assert property (mem_req.wr
    |-> memory_data_pins_oe && memory_data_pins_o == stack_next) else $error("mem write data");
  chk_mem_pop: assert property (mem_req.rd && !mem_req.fetch && !mem_wait
    |=> mem_load_pop && mem_load_data == $past(memory_data_pins_i)) else $error("mem read");
endmodule
bind pbmp_top pbmp_top_chk u_chk (.clock, .rstn, .pb_req, .pb_wait, .pb_rdata, .pb_push,
  .timer1_count, .timer1_preload, .timer1_load, .mem_req, .mem_wait, .stack_next,
  .mem_load_data, .mem_load_pop, .memory_data_pins_o, .memory_data_pins_oe,
  .memory_data_pins_i, .peripheral_address_pins, .peripheral_data_pins_i,
  .peripheral_rd, .peripheral_wr);

// ---- sim/pbmp_ext_model.sv ----
// External memory and off-chip peripheral devices
`timescale 1ns/1ps
module pbmp_ext_model (
  input  wire logic        clock,
  input  wire logic [19:1] memory_address_pins,
  input  wire logic [15:0] memory_data_pins_o,
  input  wire logic        memory_data_pins_oe,
  output logic      [15:0] memory_data_pins_i,
  input  wire logic [2:0]  peripheral_address_pins,
  input  wire logic [15:0] peripheral_data_pins_o,
  input  wire logic        peripheral_data_pins_oe,
  input  wire logic        peripheral_rd,
  input  wire logic        peripheral_wr,
  output logic      [15:0] peripheral_data_pins_i
);
  logic [15:0] mem [0:255];
  logic [15:0] preg [0:7];
  logic [15:0] idle = 16'h5A5A;
  logic [7:0]  idx;
  // Page bits kept so pages stay apart
  assign idx = {memory_address_pins[19:16], memory_address_pins[4:1]};
  always @(posedge clock) begin
    idle <= ~idle;
    if (memory_data_pins_oe) begin
      mem[idx] <= memory_data_pins_o;
    end
    if (peripheral_wr) begin
      preg[peripheral_address_pins] <= peripheral_data_pins_o;
    end
  end
  assign memory_data_pins_i = memory_data_pins_oe ? memory_data_pins_o : mem[idx];
  assign peripheral_data_pins_i = peripheral_data_pins_oe ? peripheral_data_pins_o :
                                  peripheral_rd ? preg[peripheral_address_pins] : idle;
endmodule

// ---- sim/pbmp_top_tb.sv ----
// Self-checking bench for the paged bus block
`timescale 1ns/1ps
module pbmp_top_tb;
  import pbmp_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, mac_load = 1'b0, fetch_done = 1'b0;
  pbmp_pb_req_t pb_req = '0;
  pbmp_mem_req_t mem_req = '0;
  logic [15:0] timer1_count = 16'h1234, timer2_count = 16'h5678, stack_top = '0, stack_next = '0;
  logic [15:0] mac_low = 16'h0F1E, mac_mid = 16'h2D3C;
  logic [31:0] product = 32'h2D3C0F1E;
  logic pb_wait, timer1_load, timer2_load, mem_wait, mem_load_pop, irq_holdoff;
  logic data_page_select, memory_data_pins_oe, peripheral_data_pins_oe, peripheral_rd;
  logic peripheral_wr, scratch_inc = 1'b0, scratch_dec = 1'b0;
  logic [15:0] pb_rdata, timer1_preload, timer2_preload, mem_load_data, memory_data_pins_o;
  logic [15:0] memory_data_pins_i, peripheral_data_pins_o, peripheral_data_pins_i, s_rdata;
  logic [19:1] memory_address_pins;
  logic [2:0] peripheral_address_pins;
  pbmp_push_t pb_push;
  int err_total = 0, num_checks = 0;
  always #2 clock = ~clock;
  pbmp_top #(.VARIANT(VAR_MAC)) u_dut (.clock, .rstn, .pb_req, .pb_wait, .pb_rdata, .pb_push,
    .timer1_count, .timer2_count, .timer1_preload, .timer2_preload, .timer1_load,
    .timer2_load, .product, .mac_load, .mac_low, .mac_mid, .scratch_inc,
    .scratch_dec, .mem_req, .fetch_done, .stack_top, .stack_next, .mem_wait,
    .mem_load_data, .mem_load_pop, .irq_holdoff, .data_page_select, .memory_address_pins,
    .memory_data_pins_o, .memory_data_pins_oe, .memory_data_pins_i, .peripheral_address_pins,
    .peripheral_data_pins_o, .peripheral_data_pins_oe, .peripheral_data_pins_i,
    .peripheral_rd, .peripheral_wr);
  // Scratch variant shares the request side, only its read data is watched
  pbmp_top #(.VARIANT(VAR_SCRATCH)) u_scr (.clock, .rstn, .pb_req, .pb_wait(), .pb_push(),
    .pb_rdata(s_rdata), .timer1_count, .timer2_count, .timer1_preload(), .timer2_preload(),
    .timer1_load(), .timer2_load(), .product, .mac_load, .mac_low, .mac_mid, .scratch_inc,
    .scratch_dec, .mem_req, .fetch_done, .stack_top, .stack_next, .mem_wait(),
    .mem_load_data(), .mem_load_pop(), .irq_holdoff(), .data_page_select(),
    .memory_address_pins(), .memory_data_pins_o(), .memory_data_pins_oe(),
    .memory_data_pins_i, .peripheral_address_pins(), .peripheral_data_pins_o(),
    .peripheral_data_pins_oe(), .peripheral_data_pins_i, .peripheral_rd(), .peripheral_wr());
  pbmp_ext_model u_ext (.clock, .memory_address_pins, .memory_data_pins_o,
    .memory_data_pins_oe, .memory_data_pins_i, .peripheral_address_pins,
    .peripheral_data_pins_o, .peripheral_data_pins_oe, .peripheral_rd, .peripheral_wr,
    .peripheral_data_pins_i);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pb_op(input logic wr, input logic [4:0] a, input logic [15:0] d, input int ew);
    int w;
    w = 0;
    @(negedge clock);
    pb_req = '{!wr, wr, a, d};
    #1;
    while (pb_wait && w < 4) begin
      w++;
      @(negedge clock);
    end
    if (w == 4) begin
      err_total++;
      complete_run();
    end
    check("pb waits", w, ew);
    @(posedge clock);
    @(negedge clock);
    pb_req = '0;
    if (!wr) begin
      check("pb_rdata", pb_rdata, d);
      check("pb_push", pb_push, PUSH_FULL);
    end
  endtask
  task automatic mem_op(input pbmp_mem_req_t r, input logic [15:0] t, n,
                        input logic [3:0] pg, input int ew);
    int w;
    w = 0;
    @(negedge clock);
    mem_req = r;
    stack_top = t;
    stack_next = n;
    fetch_done = r.fetch;
    #1;
    check("page", memory_address_pins[19:16], pg);
    check("offset", memory_address_pins[15:1], t[15:1]);
    while (mem_wait && w < 4) begin
      w++;
      @(negedge clock);
    end
    if (w == 4) begin
      err_total++;
      complete_run();
    end
    check("mem waits", w, ew);
    @(posedge clock);
    @(negedge clock);
    mem_req = '0;
    fetch_done = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    check("select", data_page_select, 1'b0);
    pb_op(0, PB_CPR, 16'h0000, 0);
    pb_op(0, PB_DPR, 16'h0000, 0);
    pb_op(0, PB_TIMER1, 16'h1234, 0);
    pb_op(1, PB_TIMER1, 16'hA5A5, 0);
    check("preload1", timer1_preload, 16'hA5A5);
    pb_op(0, PB_TIMER1, 16'h1234, 0);
    pb_op(1, PB_TIMER2, 16'h3C3C, 0);
    check("preload2", timer2_preload, 16'h3C3C);
    check("load2", timer2_load, 1'b1);
    pb_op(0, PB_TIMER2, 16'h5678, 0);
    pb_op(1, PB_PROD_LO, 16'h0F0F, 0);
    pb_op(1, PB_PROD_HI, 16'hF0F0, 0);
    pb_op(0, PB_PROD_LO, 16'h0F0F, 0);
    pb_op(0, PB_PROD_HI, 16'hF0F0, 0);
    @(negedge clock);
    mac_load = 1'b1;
    @(negedge clock);
    mac_load = 1'b0;
    pb_op(0, PB_PROD_LO, 16'h0F1E, 0);
    pb_op(0, PB_PROD_HI, 16'h2D3C, 0);
    check("scratch hi", s_rdata, 16'hF0F0);
    pb_op(1, PB_PROD_LO, 16'hFFFF, 0);
    scratch_inc = 1'b1;
    @(negedge clock);
    scratch_inc = 1'b0;
    pb_op(0, PB_PROD_LO, 16'hFFFF, 0);
    check("wrap up", s_rdata, 16'h0000);
    scratch_dec = 1'b1;
    @(negedge clock);
    scratch_dec = 1'b0;
    pb_op(0, PB_PROD_LO, 16'hFFFF, 0);
    check("wrap down", s_rdata, 16'hFFFF);
    for (int i = 0; i < 8; i++) pb_op(1, PB_EXT_BASE + 5'(i), 16'hC100 + 16'(i), 0);
    for (int i = 0; i < 8; i++) pb_op(0, PB_EXT_BASE + 5'(i), 16'hC100 + 16'(i), 0);
    pb_op(1, PB_CR, 16'h2000, 0);
    pb_op(0, 5'h1B, 16'hC103, 1);
    mem_op('{0, 1, 0, 0, 0}, 16'h1234, 16'hBEEF, 4'h0, 0);
    mem_op('{1, 0, 0, 0, 0}, 16'h1234, 16'h0000, 4'h0, 0);
    check("load", mem_load_data, 16'hBEEF);
    pb_op(1, PB_DPR, 16'h0005, 0);
    pb_op(1, PB_IBC, 16'h0020, 0);
    check("select", data_page_select, 1'b1);
    mem_op('{0, 1, 0, 0, 0}, 16'h1234, 16'h1111, 4'h5, 0);
    mem_op('{1, 0, 0, 0, 0}, 16'h1234, 16'h0000, 4'h5, 0);
    check("load", mem_load_data, 16'h1111);
    pb_op(1, PB_IBC, 16'h0080, 0);
    mem_op('{1, 0, 0, 1, 0}, 16'h1234, 16'h0000, 4'h0, 1);
    check("load", mem_load_data, 16'hBEEF);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    mem_op('{1, 0, 0, 1, 0}, 16'h1234, 16'h0000, 4'h0, 0);
    pb_op(0, 5'h1B, 16'hC103, 0);
    pb_op(1, PB_CPR, 16'h0003, 0);
    check("holdoff", irq_holdoff, 1'b1);
    mem_op('{1, 0, 1, 0, 0}, 16'h0100, 16'h0000, 4'h0, 0);
    mem_op('{1, 0, 1, 0, 0}, 16'h0102, 16'h0000, 4'h3, 0);
    complete_run();
  end
endmodule
